/* File: core/cc_channel.sv */
// Purpose: one capture/compare channel with its shared counter and config.
// Assumes: cntTick is a one-cycle timebase enable from an outside divider.
// Notes: registers on a plain port; read data valid the cycle after rd.
//
// Local design decisions: the address-and-strobe port and the placing of the registers.

`timescale 1ns/1ns

module cc_channel (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic cntTick,
    input cc_pkg::bus_req_t busReq,
    output logic [cc_pkg::DATA_W-1:0] rdata,
    input wire logic pinIn,
    output logic pinOut,
    output logic pinOe,
    output logic irq
);
    import cc_pkg::*;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] ccr;
        logic [CNT_W-1:0] arr;
        logic [DATA_W-1:0] mode;
        logic arsel;
        logic ecov;
        logic intermediate_overflow_flag;
        logic [1:0] cls;
        logic flag;
        logic run;
        pin_drive_t pin;
        logic irq;
        logic [DATA_W-1:0] rdata;
    } chan_state_t;

    chan_state_t q;
    chan_state_t d;

    logic rstMeta;
    logic rstN;
    logic riseEvt;
    logic fallEvt;

    // ------------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rstMeta <= 1'b0;
            rstN <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstN <= rstMeta;
        end
    end

    edge_sync pinSync (
        .clk(clk),
        .rstN(rstN),
        .pinIn(pinIn),
        .rise(riseEvt),
        .fall(fallEvt)
    );

    // ------------------------------------------------------------------
    // decoding helpers
    // ------------------------------------------------------------------
    function automatic mode_t decodeMode(input logic [DATA_W-1:0] m);
        mode_t r;
        r = MODE_IDLE;
        if (m[MB_PULSE] && m[MB_PWM16] && !m[MB_TOG]) begin
            r = MODE_PWM16;
        end else if (m[MB_PULSE] && m[MB_TOG]) begin
            r = MODE_FREQ;
        end else if (m[MB_PULSE]) begin
            r = MODE_PULSE_MODE_ENABLE;
        end else if (m[MB_TOG]) begin
            r = MODE_HSO;
        end else if (m[MB_RISE] || m[MB_FALL]) begin
            r = MODE_CAPTURE;
        end else if (m[MB_ECOM] && m[MB_MAT]) begin
            r = MODE_SWTIMER;
        end
        return r;
    endfunction

    // low bits that take part in an n-bit pulse compare and overflow
    function automatic logic [CNT_W-1:0] lenMask(input logic [1:0] cls);
        logic [CNT_W-1:0] r;
        case (cls)
            CLS_8: r = MASK_8;
            CLS_9: r = MASK_9;
            CLS_10: r = MASK_10;
            CLS_11: r = MASK_11;
            default: r = MASK_8;
        endcase
        return r;
    endfunction

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        mode_t mode;
        logic tick;
        logic ecom;
        logic mat;
        logic evt;
        logic ovfN;
        logic ovf16;
        logic match16;
        logic [CNT_W-1:0] cntNext;
        logic [CNT_W-1:0] msk;
        logic [CNT_W-1:0] cmpN;
        mode = decodeMode(q.mode);
        tick = q.run & cntTick;
        ecom = q.mode[MB_ECOM];
        mat = q.mode[MB_MAT];
        evt = 1'b0;
        cntNext = q.cnt + CNT_ONE;
        msk = lenMask(q.cls);
        ovfN = tick && ((cntNext & msk) == RST_WORD);
        ovf16 = tick && (cntNext == RST_WORD);
        match16 = tick && (cntNext == q.ccr);
        cmpN = q.ccr;

        d = q;
        d.rdata = RST_BYTE;

        // counter
        if (tick) begin
            d.cnt = cntNext;
        end

        // register writes
        if (busReq.wr) begin
            case (busReq.addr)
                OFF_MODE: begin
                    d.mode = busReq.wdata;
                end
                OFF_PWMCFG: begin
                    d.arsel = busReq.wdata[CB_ARSEL];
                    d.ecov = busReq.wdata[CB_ECOV];
                    d.intermediate_overflow_flag = busReq.wdata[CB_INTERMEDIATE_OVERFLOW_FLAG];
                    d.cls = busReq.wdata[CB_CLS_HI:CB_CLS_LO];
                end
                OFF_CTRL: begin
                    d.flag = busReq.wdata[TB_FLAG];
                    d.run = busReq.wdata[TB_RUN];
                end
                OFF_CMPLO: begin
                    if (q.arsel && mode == MODE_PULSE_MODE_ENABLE && q.cls != CLS_8) begin
                        d.arr[7:0] = busReq.wdata;
                    end else begin
                        d.ccr[7:0] = busReq.wdata;
                        d.mode[MB_ECOM] = 1'b0;
                    end
                end
                OFF_CMPHI: begin
                    if (q.arsel && mode == MODE_PULSE_MODE_ENABLE && q.cls != CLS_8) begin
                        d.arr[15:8] = busReq.wdata;
                    end else begin
                        d.ccr[15:8] = busReq.wdata;
                        d.mode[MB_ECOM] = 1'b1;
                    end
                end
                OFF_CNTLO: begin
                    d.cnt[7:0] = busReq.wdata;
                end
                OFF_CNTHI: begin
                    d.cnt[15:8] = busReq.wdata;
                end
                default: begin
                end
            endcase
        end

        // register reads
        if (busReq.rd) begin
            case (busReq.addr)
                OFF_MODE: d.rdata = q.mode;
                OFF_PWMCFG: begin
                    d.rdata[CB_ARSEL] = q.arsel;
                    d.rdata[CB_ECOV] = q.ecov;
                    d.rdata[CB_INTERMEDIATE_OVERFLOW_FLAG] = q.intermediate_overflow_flag;
                    d.rdata[CB_CLS_HI:CB_CLS_LO] = q.cls;
                end
                OFF_CTRL: begin
                    d.rdata[TB_FLAG] = q.flag;
                    d.rdata[TB_RUN] = q.run;
                end
                OFF_CMPLO: begin
                    if (q.arsel && mode == MODE_PULSE_MODE_ENABLE && q.cls != CLS_8) begin
                        d.rdata = q.arr[7:0];
                    end else begin
                        d.rdata = q.ccr[7:0];
                    end
                end
                OFF_CMPHI: begin
                    if (q.arsel && mode == MODE_PULSE_MODE_ENABLE && q.cls != CLS_8) begin
                        d.rdata = q.arr[15:8];
                    end else begin
                        d.rdata = q.ccr[15:8];
                    end
                end
                OFF_CNTLO: d.rdata = q.cnt[7:0];
                OFF_CNTHI: d.rdata = q.cnt[15:8];
                default: d.rdata = RST_BYTE;
            endcase
        end

        // channel modes; hardware updates follow software writes
        case (mode)
            MODE_CAPTURE: begin
                if ((riseEvt && q.mode[MB_RISE]) || (fallEvt && q.mode[MB_FALL])) begin
                    d.ccr = q.cnt;
                    evt = 1'b1;
                end
            end
            MODE_SWTIMER: begin
                if (match16) begin
                    evt = 1'b1;
                end
            end
            MODE_HSO: begin
                // disabled comparator leaves the pin where it is
                if (match16 && ecom) begin
                    d.pin.pinOut = ~q.pin.pinOut;
                    evt = 1'b1;
                end
            end
            MODE_FREQ: begin
                if (ecom && tick && cntNext[7:0] == q.ccr[7:0]) begin
                    d.pin.pinOut = ~q.pin.pinOut;
                    // a zero step wraps back to the same value: 256 clocks
                    d.ccr[7:0] = q.ccr[7:0] + q.ccr[15:8];
                end
                if (mat && match16) begin
                    evt = 1'b1;
                end
            end
            MODE_PULSE_MODE_ENABLE: begin
                // at the wrap the freshly reloaded value is the one compared
                if (ovfN) begin
                    if (q.cls == CLS_8) begin
                        cmpN = {RST_BYTE, q.ccr[15:8]};
                        d.ccr[7:0] = q.ccr[15:8];
                    end else begin
                        cmpN = q.arr;
                        d.ccr = q.arr;
                    end
                end
                if (!ecom) begin
                    d.pin.pinOut = 1'b0;
                end else if (tick && ((cntNext & msk) == (cmpN & msk))) begin
                    // match wins over the wrap so a zero value gives full duty
                    d.pin.pinOut = 1'b1;
                    if (mat) begin
                        evt = 1'b1;
                    end
                end else if (ovfN) begin
                    d.pin.pinOut = 1'b0;
                end
            end
            MODE_PWM16: begin
                if (!ecom) begin
                    d.pin.pinOut = 1'b0;
                end else if (match16) begin
                    d.pin.pinOut = 1'b1;
                    if (mat) begin
                        evt = 1'b1;
                    end
                end else if (ovf16) begin
                    d.pin.pinOut = 1'b0;
                end
            end
            default: begin
            end
        endcase

        // flags: a hardware set wins over a software clear
        if (ovfN) begin
            d.intermediate_overflow_flag = 1'b1;
        end
        if (evt) begin
            d.flag = 1'b1;
        end

        d.pin.pinOe = (mode == MODE_HSO) || (mode == MODE_FREQ) ||
                      (mode == MODE_PULSE_MODE_ENABLE) || (mode == MODE_PWM16);
        d.irq = (d.flag & d.mode[MB_IE]) | (d.intermediate_overflow_flag & d.ecov);
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign rdata = q.rdata;
    assign pinOut = q.pin.pinOut;
    assign pinOe = q.pin.pinOe;
    assign irq = q.irq;
endmodule

/* File: core/edge_sync.sv */
// Purpose: two-stage synchroniser and edge detector for the channel pin.
// Assumes: pin held at each level at least two system clocks.
// Notes: first stage is read only by the second stage.

`timescale 1ns/1ns

module edge_sync (
    input wire logic clk,
    input wire logic rstN,
    input wire logic pinIn,
    output logic rise,
    output logic fall
);
    typedef struct packed {
        logic meta;
        logic sync;
        logic last;
        logic rise;
        logic fall;
    } sync_state_t;

    sync_state_t q;
    sync_state_t d;

    always_comb begin
        d = q;
        d.meta = pinIn;
        d.sync = q.meta;
        d.last = q.sync;
        d.rise = q.sync & ~q.last;
        d.fall = ~q.sync & q.last;
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign rise = q.rise;
    assign fall = q.fall;
endmodule

/* File: pkg/cc_pkg.sv */
// Purpose: constants, types and register map of the capture/compare channel.
// Assumes: one channel beside a shared 16-bit counter; 8-bit register port.
// Notes: register offsets are word indices on the plain register port.
// Behaviour
// - qualifying pin edge copies the counter into the capture/compare register.
// - capture sets the channel flag; interrupt only when channel enable is set.
// - channel flag stays set until software writes it clear.
// - software timer compares counter with register; equality sets flag.
// - software timer selected by comparator and match enables, others clear.
// - writing compare low byte clears comparator enable; high byte sets it.
// - high-speed output toggles pin and sets flag on each 16-bit match.
// - high-speed output with comparator disabled holds the pin level.
// - frequency output matches low bytes, toggles pin, adds high byte to low.
// - frequency high byte is half period; zero acts as 256 clocks.
// - frequency output needs comparator, toggle, pulse bits; match flags 16-bit equality.
// - 8-bit pulse mode drives pin high on low-byte match, low on overflow.
// - 8-bit pulse mode reloads compare low byte from high byte on wrap.
// - 8-bit pulse mode needs comparator, pulse bits, length zero; match sets flag.
// - intermediate overflow flag set on each cycle-length overflow, every 256 to 2048 clocks.
// - 8-bit pulse high time equals 256 minus compare high byte.
// - 8 to 11-bit pulse channels share one cycle length; others ignore it.
// - two-bit cycle length selects 8, 9, 10 or 11 bits; 16-bit ignores it.
// - comparator disabled stops toggling and forces pulse outputs low.
// - in 9 to 11-bit pulse, select bit routes compare access to auto-reload.
// - shared enable lets overflow flag interrupt; overflow bit follows cycle length.

package cc_pkg;

    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam int CNT_W = 16;

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFF_MODE = 3'h0;
    localparam logic [ADDR_W-1:0] OFF_PWMCFG = 3'h1;
    localparam logic [ADDR_W-1:0] OFF_CTRL = 3'h2;
    localparam logic [ADDR_W-1:0] OFF_CMPLO = 3'h3;
    localparam logic [ADDR_W-1:0] OFF_CMPHI = 3'h4;
    localparam logic [ADDR_W-1:0] OFF_CNTLO = 3'h5;
    localparam logic [ADDR_W-1:0] OFF_CNTHI = 3'h6;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int MB_PWM16 = 7;
    localparam int MB_ECOM = 6;
    localparam int MB_RISE = 5;
    localparam int MB_FALL = 4;
    localparam int MB_MAT = 3;
    localparam int MB_TOG = 2;
    localparam int MB_PULSE = 1;
    localparam int MB_IE = 0;

    localparam int CB_ARSEL = 7;
    localparam int CB_ECOV = 6;
    localparam int CB_INTERMEDIATE_OVERFLOW_FLAG = 5;
    localparam int CB_CLS_HI = 1;
    localparam int CB_CLS_LO = 0;

    localparam int TB_FLAG = 0;
    localparam int TB_RUN = 6;

    // ------------------------------------------------------------------
    // reset values and constants
    // ------------------------------------------------------------------
    localparam logic [DATA_W-1:0] RST_BYTE = 8'h00;
    localparam logic [CNT_W-1:0] RST_WORD = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
    localparam logic [1:0] CLS_8 = 2'h0;
    localparam logic [1:0] CLS_9 = 2'h1;
    localparam logic [1:0] CLS_10 = 2'h2;
    localparam logic [1:0] CLS_11 = 2'h3;
    localparam logic [CNT_W-1:0] MASK_8 = 16'h00ff;
    localparam logic [CNT_W-1:0] MASK_9 = 16'h01ff;
    localparam logic [CNT_W-1:0] MASK_10 = 16'h03ff;
    localparam logic [CNT_W-1:0] MASK_11 = 16'h07ff;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_IDLE = 3'h0,
        MODE_CAPTURE = 3'h1,
        MODE_SWTIMER = 3'h3,
        MODE_HSO = 3'h2,
        MODE_FREQ = 3'h6,
        MODE_PULSE_MODE_ENABLE = 3'h7,
        MODE_PWM16 = 3'h5
    } mode_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;

    typedef struct packed {
        logic pinOut;
        logic pinOe;
    } pin_drive_t;

endpackage

/* File: testbench/cc_channel_sva.sv */
// Purpose: port-level checks of the capture/compare channel.
// Assumes: register writes mirrored here to know the mode.
// Notes: bound to every cc_channel instance.

`timescale 1ns/1ns

module cc_channel_sva (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic cntTick,
    input cc_pkg::bus_req_t busReq,
    input wire logic [cc_pkg::DATA_W-1:0] rdata,
    input wire logic pinIn,
    input wire logic pinOut,
    input wire logic pinOe,
    input wire logic irq
);
    import cc_pkg::*;

    // ------------------------------------------------------------------
    // mirrored configuration
    // ------------------------------------------------------------------
    logic [7:0] modeQ, cfgQ, hiQ;
    logic [8:0] tickQ;
    logic [2:0] wrH, tkH;
    logic armQ, pinQ, route, freq, drv, pwmOff, hsoOff;

    assign route = cfgQ[CB_ARSEL] && modeQ[MB_PULSE] && cfgQ[1:0] != 2'h0;
    assign freq = modeQ[MB_ECOM] && modeQ[MB_TOG] && modeQ[MB_PULSE];
    assign drv = modeQ[MB_PULSE] || modeQ[MB_TOG];
    assign pwmOff = modeQ[MB_PULSE] && !modeQ[MB_TOG] && !modeQ[MB_ECOM];
    assign hsoOff = modeQ[MB_TOG] && !modeQ[MB_PULSE] && !modeQ[MB_ECOM];

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            modeQ <= 8'h00;
            cfgQ <= 8'h00;
            hiQ <= 8'h00;
            tickQ <= 9'h000;
            wrH <= 3'h0;
            tkH <= 3'h0;
            armQ <= 1'b0;
            pinQ <= 1'b0;
        end else begin
            pinQ <= pinOut;
            wrH <= {wrH[1:0], busReq.wr};
            tkH <= {tkH[1:0], cntTick};
            tickQ <= (pinOut != pinQ) ? {8'h00, cntTick} : tickQ + {8'h00, cntTick};
            armQ <= freq && !busReq.wr && (armQ || pinOut != pinQ);
            if (busReq.wr) begin
                case (busReq.addr)
                    OFF_MODE: modeQ <= busReq.wdata;
                    OFF_PWMCFG: cfgQ <= busReq.wdata;
                    OFF_CMPLO: if (!route) modeQ[MB_ECOM] <= 1'b0;
                    OFF_CMPHI: if (!route) begin
                        modeQ[MB_ECOM] <= 1'b1;
                        hiQ <= busReq.wdata;
                    end
                    default: ;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    sequence s_low_write;
        busReq.wr && busReq.addr == OFF_CMPLO && !route && pwmOff == 1'b0 && modeQ[MB_PULSE]
            && !modeQ[MB_TOG];
    endsequence

    a_irq_gated: assert property (irq |-> modeQ[MB_IE] || cfgQ[CB_ECOV]
        || $past(modeQ[MB_IE]) || $past(cfgQ[CB_ECOV]))
        else $error("irq high with both enables clear");
    a_flag_sticky: assert property ($fell(irq) |-> |wrH[1:0])
        else $error("irq dropped without a software write");
    a_drive_modes: assert property (drv[*3] |-> pinOe)
        else $error("pin not driven in an output mode");
    a_pwm_off_low: assert property (pwmOff[*3] |-> !pinOut)
        else $error("pulse output high with comparator off");
    a_hso_hold: assert property (hsoOff[*3] |-> $stable(pinOut))
        else $error("toggle output moved with comparator off");
    a_low_write_off: assert property (s_low_write |-> ##2 !pinOut)
        else $error("compare low write did not stop the pulse output");
    a_pin_on_tick: assert property ($changed(pinOut) |-> |tkH[1:0] || |wrH)
        else $error("pin moved without counter tick or write");
    a_freq_half: assert property (armQ && freq && pinOut != pinQ
        |-> tickQ == ((hiQ == 8'h00) ? 9'h100 : {1'b0, hiQ}))
        else $error("frequency half period wrong");
endmodule

bind cc_channel cc_channel_sva cc_channel_sva_inst (.clk(clk), .arst_n(arst_n),
    .cntTick(cntTick), .busReq(busReq), .rdata(rdata), .pinIn(pinIn), .pinOut(pinOut),
    .pinOe(pinOe), .irq(irq));

/* File: testbench/pin_source.sv */
// Purpose: far-side model of the channel pin.
// Assumes: outside source keeps each level at least HOLD_CYC clocks.
// Notes: pin level follows the block whenever its output enable is high.

`timescale 1ns/1ns

module pin_source #(
    parameter int HOLD_CYC = 2
) (
    input wire logic clk,
    input wire logic want,
    input wire logic pinOut,
    input wire logic pinOe,
    output logic pinIn
);
    logic ext = 1'b0;
    int held = 0;

    // level changes only after the hold time has run out
    always @(posedge clk) begin
        if (held < HOLD_CYC) begin
            held <= held + 1;
        end else if (want != ext) begin
            ext <= want;
            held <= 1;
        end
    end

    assign pinIn = pinOe ? pinOut : ext;
endmodule

/* File: testbench/tb_top.sv */
// Purpose: self-checking bench for the capture/compare channel.
// Assumes: counter ticks driven here; pin source model outside.
// Notes: each bus task leaves one idle cycle after its strobe.

`timescale 1ns/1ns

module tb_top;
    import cc_pkg::*;

    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic cntTick = 1'b0;
    logic want = 1'b0;
    bus_req_t busReq = '0;
    logic [DATA_W-1:0] rdata;
    logic pinIn, pinOut, pinOe, irq, p;
    logic [7:0] v;
    logic [7:0] capM [4] = '{8'h21, 8'h11, 8'h31, 8'h30};
    logic startL [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
    int fail_count = 0;
    int num_checks = 0;
    int n;

    always #20 clk = ~clk;

    cc_channel cc_channel_inst (.clk(clk), .arst_n(arst_n), .cntTick(cntTick),
        .busReq(busReq), .rdata(rdata), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
        .irq(irq));
    pin_source pin_source_inst (.clk(clk), .want(want), .pinOut(pinOut), .pinOe(pinOe),
        .pinIn(pinIn));

    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task results;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task wr(input logic [2:0] a, input logic [7:0] d);
        busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        busReq <= '0;
        @(posedge clk);
    endtask

    task rd(input logic [2:0] a, input logic [7:0] exp, input string name);
        busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        busReq <= '0;
        #1 v = rdata;
        @(posedge clk);
        check(name, {8'h00, v}, {8'h00, exp});
    endtask

    task pulse;
        cntTick <= 1'b1;
        @(posedge clk);
        cntTick <= 1'b0;
        @(posedge clk);
        #1;
    endtask

    task wait_pin(input logic lvl);
        n = 0;
        while (pinOut !== lvl && n < 3000) begin
            @(posedge clk);
            #1 n++;
        end
        if (n >= 3000) begin
            fail_count++;
            results;
        end
    endtask

    // length of the next complete stretch of pinOut at lvl
    task measure(input logic lvl, input int exp);
        wait_pin(!lvl);
        wait_pin(lvl);
        wait_pin(!lvl);
        check("pin width", 16'(n), 16'(exp));
    endtask

    task load(input logic [7:0] lo, input logic [7:0] hi, input logic [7:0] mode);
        wr(OFF_CMPLO, lo);
        wr(OFF_CMPHI, hi);
        wr(OFF_MODE, mode);
    endtask

    // ------------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        for (int a = 0; a < 8; a++) rd(3'(a), 8'h00, "reset value");
        wr(OFF_MODE, 8'h08);
        wr(OFF_CMPHI, 8'h00);
        rd(OFF_MODE, 8'h48, "ecom set");
        wr(OFF_CMPLO, 8'h00);
        rd(OFF_MODE, 8'h08, "ecom clear");
        for (int i = 0; i < 4; i++) begin
            wr(OFF_MODE, 8'h00);
            want <= startL[i];
            repeat (6) @(posedge clk);
            wr(OFF_CTRL, 8'h00);
            wr(OFF_CNTLO, 8'(48 + i));
            wr(OFF_CNTHI, 8'h12);
            wr(OFF_MODE, capM[i]);
            want <= !startL[i];
            repeat (8) @(posedge clk);
            check("capture irq", {15'h0, irq}, {15'h0, capM[i][0]});
            rd(OFF_CMPLO, 8'(48 + i), "capture low");
            rd(OFF_CMPHI, 8'h12, "capture high");
            rd(OFF_CTRL, 8'h01, "flag kept");
            wr(OFF_CTRL, 8'h00);
            rd(OFF_CTRL, 8'h00, "flag cleared");
        end
        load(8'h10, 8'h00, 8'h49);
        wr(OFF_CMPLO, 8'h10);
        wr(OFF_CMPHI, 8'h00);
        wr(OFF_CNTLO, 8'h0e);
        wr(OFF_CNTHI, 8'h00);
        wr(OFF_CTRL, 8'h40);
        pulse;
        rd(OFF_CTRL, 8'h40, "timer early");
        pulse;
        rd(OFF_CTRL, 8'h41, "timer match");
        check("timer irq", {15'h0, irq}, 16'h0001);
        wr(OFF_CTRL, 8'h40);
        load(8'h05, 8'h00, 8'h4c);
        wr(OFF_CNTLO, 8'h04);
        p = pinOut;
        pulse;
        check("hso toggle", {15'h0, pinOut}, {15'h0, !p});
        rd(OFF_CTRL, 8'h41, "hso flag");
        wr(OFF_CMPLO, 8'h05);
        wr(OFF_CNTLO, 8'h04);
        p = pinOut;
        pulse;
        check("hso hold", {15'h0, pinOut}, {15'h0, p});
        wr(OFF_CTRL, 8'h40);
        load(8'h00, 8'h03, 8'h46);
        cntTick <= 1'b1;
        measure(1'b1, 3);
        load(8'h00, 8'h00, 8'h46);
        measure(1'b1, 256);
        cntTick <= 1'b0;
        wr(OFF_PWMCFG, 8'h00);
        load(8'h40, 8'h40, 8'h4a);
        wr(OFF_CTRL, 8'h40);
        cntTick <= 1'b1;
        measure(1'b1, 192);
        rd(OFF_PWMCFG, 8'h20, "low byte overflow");
        rd(OFF_CTRL, 8'h41, "pulse match flag");
        wr(OFF_CMPLO, 8'h40);
        repeat (300) @(posedge clk);
        #1 check("pulse off", {15'h0, pinOut}, 16'h0000);
        cntTick <= 1'b0;
        wr(OFF_PWMCFG, 8'hc1);
        wr(OFF_MODE, 8'h42);
        wr(OFF_CMPLO, 8'h80);
        wr(OFF_CMPHI, 8'h00);
        rd(OFF_MODE, 8'h42, "routed write");
        rd(OFF_CMPLO, 8'h80, "reload low");
        cntTick <= 1'b1;
        measure(1'b1, 384);
        repeat (2) @(posedge clk);
        #1 check("overflow irq", {15'h0, irq}, 16'h0001);
        results;
    end
endmodule
